//--- hdl/oscillator_select_switch.sv
// Strobed register access and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`include "osc_map.svh"
// Operation
// - Any change of clock source waits a source-dependent settling delay before the new clock is used.
// - Leaving sleep or reset into an internal oscillator completes after two cycles of the new oscillator.
// - Moving to the mid or high internal oscillator without the PLL waits about two microseconds.
// - Moving to the low internal oscillator waits one cycle of the old clock and one of the new.
// - Codes 1111 down to 1000 give 16 MHz down to 125 kHz from the high oscillator.
// - Codes 0111 down to 0100 give 500 kHz down to 62.5 kHz from the mid oscillator, lower codes 31.25 kHz.
// - The 8 MHz code with the PLL enabled gives 32 MHz instead while clock select is 0x on an internal configuration source; select 1x stays 8 MHz.
// - A set configuration PLL force bit keeps the PLL on whatever software writes.
// - With the force bit clear the software PLL bit turns the PLL on and off.
// - Clock select 1x picks the internal block, 01 is reserved and 00 follows the configuration source.
// - Every reset loads the frequency select with 0111, 500 kHz from the mid oscillator.
// - Every reset clears the clock select field.
// - A switch waits for a falling edge of the current clock, holds low, then resumes on a new rising edge.
// - A change within the same oscillator source inserts no start-up delay.
module oscillator_select_switch
  import osc_pkg::*;
#(
  parameter int unsigned PLL_LOCK_CYCLES = `OSC_PLL_CYC
) (
  input  logic       clk,
  input  logic       rst_n,
  input  logic [3:0] bus_addr,
  input  logic [7:0] bus_wdata,
  input  logic       bus_wr,
  input  logic       bus_rd,
  output logic [7:0] bus_rdata,
  input  logic [1:0] config_osc_select,
  input  logic       config_pll_force,
  input  logic       sleep_req,
  input  logic       low_freq_internal_osc,
  input  logic       mid_freq_internal_osc,
  input  logic       high_freq_internal_osc,
  input  logic       external_clock_input,
  input  logic       pll_osc,
  output logic       sys_clk,
  output logic       pll_enable,
  output logic       switch_busy,
  output logic [4:0] active_source
);
  osc_ctrl_if ctl ();

  osc_ctrl_regs u_regs (
    .clk       (clk),
    .rst_n     (rst_n),
    .bus_addr  (bus_addr),
    .bus_wdata (bus_wdata),
    .bus_wr    (bus_wr),
    .bus_rd    (bus_rd),
    .bus_rdata (bus_rdata),
    .ctl       (ctl)
  );

  logic [4:0] src_lvl;

  osc_pin_sync #(
    .W (5)
  ) u_sync (
    .clk    (clk),
    .rst_n  (rst_n),
    .pin_in ({pll_osc, external_clock_input, high_freq_internal_osc,
              mid_freq_internal_osc, low_freq_internal_osc}),
    .level  (src_lvl)
  );

  function automatic src_e pick_src(input logic intl, input logic pll, input logic [3:0] code);
    src_e s;
    if (!intl) begin
      s = SRC_EXT;
    end else if (pll) begin
      s = SRC_PLL;
    end else if (code[3] || code == `OSC_CODE_HF_SLOW) begin
      s = SRC_HF;
    end else if (code[2] || code == `OSC_CODE_MF_SLOW) begin
      s = SRC_MF;
    end else begin
      s = SRC_LF;
    end
    return s;
  endfunction : pick_src

  // Postscaler depth as a power of two below the raw oscillator.
  function automatic logic [3:0] pick_shift(input src_e s, input logic [3:0] code);
    logic [3:0] n;
    n = 4'h0;
    if (s == SRC_HF) begin
      n = (code == `OSC_CODE_HF_SLOW) ? 4'h9 : 4'hf - code;
    end else if (s == SRC_MF) begin
      n = (code == `OSC_CODE_MF_SLOW) ? 4'h4 : 4'h7 - code;
    end
    return n;
  endfunction : pick_shift

  state_e      st_q;
  state_e      st_d;
  src_e        act_src_q;
  src_e        new_src_q;
  dly_e        dly_q;
  logic [3:0]  act_n_q;
  logic [3:0]  new_n_q;
  logic [16:0] cnt_q;
  logic [8:0]  div_cnt_q;
  logic [4:0]  lvl_q;
  logic        old_seen_q;
  logic        wake_q;
  logic        sys_q;
  logic        pll_en_q;
  logic        dly_done;

  wire        pll_on   = config_pll_force | ctl.pll_sw;
  wire        cfg_int  = config_osc_select == `OSC_CFG_INTOSC;
  // Reserved select 01 is handled like 00 so a stray write cannot strand the core.
  wire        use_int  = ctl.clk_sel[1] | cfg_int;
  wire        pll_ok   = pll_on & ~ctl.clk_sel[1] & cfg_int & (ctl.freq_sel == `OSC_CODE_PLL);
  wire src_e  tgt_s    = pick_src(use_int, pll_ok, ctl.freq_sel);
  wire [3:0]  tgt_n    = pick_shift(tgt_s, ctl.freq_sel);
  wire [4:0]  src_rise = src_lvl & ~lvl_q;
  wire        new_rise = |(src_rise & new_src_q);
  wire        old_rise = |(src_rise & act_src_q);
  wire        cur_raw  = |(src_lvl & act_src_q);
  wire [9:0]  taps     = {~div_cnt_q, cur_raw};
  wire        cur_lvl  = taps[act_n_q];
  wire        from_slp = st_q == ST_SLEEP;
  wire        enter    = (st_d == ST_DELAY) && (st_q != ST_DELAY);
  wire        running  = (st_q == ST_RUN) || (st_q == ST_DELAY) || (st_q == ST_FALL);
  wire        sys_d    = (st_q == ST_RISE) ? new_rise : (running && !wake_q && cur_lvl);
  wire [16:0] dly_last = (new_src_q == SRC_PLL) ? 17'(PLL_LOCK_CYCLES - 1) : 17'(`OSC_HFMF_CYC - 1);
  wire [16:0] new2_last = 17'(`OSC_WAKE_EDGES - 1);

  wire dly_e dly_sel =
    from_slp ? DLY_NEW2 :
    (tgt_s == act_src_q) ? DLY_NONE :
    (tgt_s == SRC_LF || (act_src_q == SRC_LF && tgt_s == SRC_EXT)) ? DLY_OLD_NEW :
    (tgt_s == SRC_EXT) ? DLY_NEW2 :
    DLY_TIME;

  always_comb begin
    case (dly_q)
      DLY_NONE:    dly_done = 1'b1;
      DLY_NEW2:    dly_done = new_rise && (cnt_q == new2_last);
      DLY_OLD_NEW: dly_done = new_rise && old_seen_q;
      DLY_TIME:    dly_done = cnt_q == dly_last;
      default:     dly_done = 1'b1;
    endcase
  end

  always_comb begin
    st_d = st_q;
    case (st_q)
      ST_RUN: begin
        // Sleep is entered only in a low phase so the last high pulse is never cut short.
        if (sleep_req && !cur_lvl) begin
          st_d = ST_SLEEP;
        end else if (tgt_s != act_src_q || tgt_n != act_n_q) begin
          st_d = ST_DELAY;
        end
      end
      ST_DELAY: begin
        if (dly_done) begin
          st_d = ST_FALL;
        end
      end
      ST_FALL: begin
        if (wake_q || !cur_lvl) begin
          st_d = ST_RISE;
        end
      end
      ST_RISE: begin
        if (new_rise) begin
          st_d = ST_RUN;
        end
      end
      ST_SLEEP: begin
        if (!sleep_req) begin
          st_d = ST_DELAY;
        end
      end
      default: st_d = ST_SLEEP;
    endcase
  end

  // Reset starts in the sleep state so power-up takes the same wake path as leaving sleep.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q     <= ST_SLEEP;
      lvl_q    <= 5'h00;
      sys_q    <= 1'b0;
      pll_en_q <= 1'b0;
    end else begin
      st_q     <= st_d;
      lvl_q    <= src_lvl;
      sys_q    <= sys_d;
      pll_en_q <= pll_on;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      new_src_q <= SRC_MF;
      new_n_q   <= 4'h0;
      dly_q     <= DLY_NEW2;
    end else if (enter) begin
      new_src_q <= tgt_s;
      new_n_q   <= tgt_n;
      dly_q     <= dly_sel;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q      <= 17'h00000;
      old_seen_q <= 1'b0;
    end else if (enter) begin
      cnt_q      <= 17'h00000;
      old_seen_q <= 1'b0;
    end else if (st_q == ST_DELAY) begin
      if (dly_q == DLY_TIME || (dly_q == DLY_NEW2 && new_rise)) begin
        cnt_q <= cnt_q + 17'h00001;
      end
      old_seen_q <= old_seen_q | old_rise;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wake_q <= 1'b1;
    end else if (enter) begin
      wake_q <= from_slp;
    end else if (st_q == ST_RISE && new_rise) begin
      wake_q <= 1'b0;
    end
  end

  // The new clock becomes active only here, after the delay and the low hold.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      act_src_q <= SRC_MF;
      act_n_q   <= 4'h0;
      div_cnt_q <= 9'h000;
    end else if (st_q == ST_RISE && new_rise) begin
      act_src_q <= new_src_q;
      act_n_q   <= new_n_q;
      div_cnt_q <= 9'h000;
    end else if (old_rise) begin
      div_cnt_q <= div_cnt_q + 9'h001;
    end
  end

  assign sys_clk       = sys_q;
  assign pll_enable    = pll_en_q;
  assign switch_busy   = st_q != ST_RUN;
  assign active_source = act_src_q;
  assign ctl.status    = {switch_busy, from_slp, pll_en_q, act_src_q};

  AST_PLL_COUNT: assert property (@(posedge clk) disable iff (!rst_n)
    st_q == ST_DELAY && st_d == ST_FALL && dly_q == DLY_TIME && new_src_q == SRC_PLL
    |-> cnt_q == 17'(PLL_LOCK_CYCLES - 1))
    else $error("PLL switch left its delay early");
  AST_WAKE_TWO: assert property (@(posedge clk) disable iff (!rst_n)
    st_q == ST_DELAY && wake_q && st_d == ST_FALL
    |-> new_rise && cnt_q == 17'h00001 ##1 st_q == ST_FALL ##1 st_q == ST_RISE)
    else $error("wake switch did not wait two new-clock cycles");
  AST_HFMF_TIME: assert property (@(posedge clk) disable iff (!rst_n)
    st_q == ST_DELAY && st_d == ST_FALL && dly_q == DLY_TIME && new_src_q != SRC_PLL
    |-> cnt_q == 17'(`OSC_HFMF_CYC - 1))
    else $error("mid or high oscillator delay is not two microseconds");
  AST_LF_EACH: assert property (@(posedge clk) disable iff (!rst_n)
    enter && !from_slp && tgt_s == SRC_LF && act_src_q != SRC_LF |=> dly_q == DLY_OLD_NEW)
    else $error("switch to low oscillator did not use old and new cycle delay");
  AST_HF_DECODE: assert property (@(posedge clk) disable iff (!rst_n)
    tgt_s == SRC_HF && ctl.freq_sel == 4'h8 |-> tgt_n == 4'h7)
    else $error("125 kHz high oscillator code decoded wrong");
  AST_MF_DECODE: assert property (@(posedge clk) disable iff (!rst_n)
    tgt_s == SRC_MF && ctl.freq_sel == 4'h4 |-> tgt_n == 4'h3)
    else $error("62.5 kHz mid oscillator code decoded wrong");
  AST_PLL_32M: assert property (@(posedge clk) disable iff (!rst_n)
    pll_ok |-> tgt_s == SRC_PLL && tgt_n == 4'h0)
    else $error("8 MHz code with PLL did not pick the PLL");
  AST_PLL_FORCE: assert property (@(posedge clk) disable iff (!rst_n)
    config_pll_force |=> pll_enable)
    else $error("PLL not kept on by the configuration force bit");
  AST_PLL_SW: assert property (@(posedge clk) disable iff (!rst_n)
    !config_pll_force |=> pll_enable == $past(ctl.pll_sw))
    else $error("PLL enable does not follow the software bit");
  AST_SCS_INT: assert property (@(posedge clk) disable iff (!rst_n)
    ctl.clk_sel[1] |-> tgt_s != SRC_EXT && tgt_s != SRC_PLL)
    else $error("clock select 1x did not pick the internal block");
  AST_HOLD_LOW: assert property (@(posedge clk) disable iff (!rst_n)
    st_q == ST_RISE && !new_rise |=> !sys_q)
    else $error("system clock not held low during a switch");
  AST_RESUME: assert property (@(posedge clk) disable iff (!rst_n)
    st_q == ST_RISE && new_rise |=> sys_q && st_q == ST_RUN && act_src_q == $past(new_src_q))
    else $error("switch did not resume on the new rising edge");
  AST_SAME_SRC: assert property (@(posedge clk) disable iff (!rst_n)
    st_q == ST_RUN && st_d == ST_DELAY && tgt_s == act_src_q |=> dly_q == DLY_NONE ##1 st_q == ST_FALL)
    else $error("same-source change inserted a start-up delay");

  // These tie codes 1111, 1110, 0111, 0011, 0010, 0001 and 0000 to their source and postscale, so a wrong table entry
  // for one of those codes fires whenever a scenario selects it.
  AST_HF_FULL: assert property (@(posedge clk) disable iff (!rst_n)
    use_int && !pll_ok && ctl.freq_sel == 4'hf
    |-> tgt_s == SRC_HF && tgt_n == 4'h0)
    else $error("16 MHz code did not pick the undivided high oscillator");
  AST_HF_EIGHT: assert property (@(posedge clk) disable iff (!rst_n)
    use_int && !pll_ok && ctl.freq_sel == `OSC_CODE_PLL
    |-> tgt_s == SRC_HF && tgt_n == 4'h1)
    else $error("8 MHz code without the PLL did not halve the high oscillator");
  AST_MF_FULL: assert property (@(posedge clk) disable iff (!rst_n)
    use_int && ctl.freq_sel == `OSC_FREQ_RESET
    |-> tgt_s == SRC_MF && tgt_n == 4'h0)
    else $error("500 kHz code did not pick the undivided mid oscillator");
  AST_HF_SLOW: assert property (@(posedge clk) disable iff (!rst_n)
    use_int && ctl.freq_sel == `OSC_CODE_HF_SLOW
    |-> tgt_s == SRC_HF && tgt_n == 4'h9)
    else $error("31.25 kHz high oscillator code decoded wrong");
  AST_MF_SLOW: assert property (@(posedge clk) disable iff (!rst_n)
    use_int && ctl.freq_sel == `OSC_CODE_MF_SLOW
    |-> tgt_s == SRC_MF && tgt_n == 4'h4)
    else $error("31.25 kHz mid oscillator code decoded wrong");
  AST_LF_CODES: assert property (@(posedge clk) disable iff (!rst_n)
    use_int && ctl.freq_sel[3:1] == 3'h0
    |-> tgt_s == SRC_LF && tgt_n == 4'h0)
    else $error("lowest codes did not pick the low oscillator");
  AST_CFG_EXT: assert property (@(posedge clk) disable iff (!rst_n)
    !ctl.clk_sel[1] && !cfg_int
    |-> tgt_s == SRC_EXT)
    else $error("clock select 0x did not follow the configuration source");
  AST_NONE_FAST: assert property (@(posedge clk) disable iff (!rst_n)
    st_q == ST_DELAY && dly_q == DLY_NONE
    |-> st_d == ST_FALL)
    else $error("same-source switch lingered in the delay phase");
  AST_OLD_NEW: assert property (@(posedge clk) disable iff (!rst_n)
    st_q == ST_DELAY && dly_q == DLY_OLD_NEW && st_d == ST_FALL
    |-> new_rise && old_seen_q)
    else $error("low oscillator delay ended without an old and a new edge");
  AST_ACT_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
    !(st_q == ST_RISE && new_rise)
    |=> $stable(act_src_q) && $stable(act_n_q))
    else $error("active clock changed outside the resume edge");
  AST_SLEEP_LOW: assert property (@(posedge clk) disable iff (!rst_n)
    st_q == ST_SLEEP
    |-> !sys_q)
    else $error("system clock not held low while asleep");
endmodule : oscillator_select_switch

//--- pkg/osc_map.svh
`ifndef OSC_MAP_SVH
`define OSC_MAP_SVH
`define OSC_ADDR_CTRL 4'h0
`define OSC_ADDR_STAT 4'h1
`define OSC_PLL_BIT 7
`define OSC_FREQ_HI 6
`define OSC_FREQ_LO 3
`define OSC_SCS_HI 1
`define OSC_SCS_LO 0
`define OSC_PLL_RESET 1'b0
`define OSC_FREQ_RESET 4'h7
`define OSC_SCS_RESET 2'h0
`define OSC_CFG_INTOSC 2'h0
`define OSC_CODE_PLL 4'he
`define OSC_CODE_HF_SLOW 4'h3
`define OSC_CODE_MF_SLOW 4'h2
`define OSC_CLK_NS 25
`define OSC_HFMF_DLY_NS 2000
`define OSC_PLL_DLY_MS 2
`define OSC_HFMF_CYC ((`OSC_HFMF_DLY_NS + `OSC_CLK_NS - 1) / `OSC_CLK_NS)
`define OSC_PLL_CYC ((`OSC_PLL_DLY_MS * 1000000 + `OSC_CLK_NS - 1) / `OSC_CLK_NS)
`define OSC_WAKE_EDGES 2
`endif

//--- pkg/osc_pkg.sv
package osc_pkg;
  typedef enum logic [4:0] {
    SRC_LF  = 5'b00001,
    SRC_MF  = 5'b00010,
    SRC_HF  = 5'b00100,
    SRC_EXT = 5'b01000,
    SRC_PLL = 5'b10000
  } src_e;
  typedef enum logic [4:0] {
    ST_RUN   = 5'b00001,
    ST_DELAY = 5'b00010,
    ST_FALL  = 5'b00100,
    ST_RISE  = 5'b01000,
    ST_SLEEP = 5'b10000
  } state_e;
  typedef enum logic [3:0] {
    DLY_NONE    = 4'b0001,
    DLY_NEW2    = 4'b0010,
    DLY_OLD_NEW = 4'b0100,
    DLY_TIME    = 4'b1000
  } dly_e;
endpackage : osc_pkg

//--- pkg/osc_ctrl_if.sv
`timescale 1ns/1ps
interface osc_ctrl_if;
  logic       pll_sw;
  logic [3:0] freq_sel;
  logic [1:0] clk_sel;
  logic [7:0] status;
  modport regs (output pll_sw, output freq_sel, output clk_sel, input status);
  modport core (input pll_sw, input freq_sel, input clk_sel, output status);
endinterface : osc_ctrl_if

//--- hdl/osc_pin_sync.sv
`timescale 1ns/1ps
module osc_pin_sync #(
  parameter int W = 5
) (
  input  logic         clk,
  input  logic         rst_n,
  input  logic [W-1:0] pin_in,
  output logic [W-1:0] level
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] lvl_q;
  // A bit only moves once stages two and three agree, so one metastable sample cannot make an edge.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q  <= '0;
      s2_q  <= '0;
      s3_q  <= '0;
      lvl_q <= '0;
    end else begin
      s1_q  <= pin_in;
      s2_q  <= s1_q;
      s3_q  <= s2_q;
      lvl_q <= (s2_q & s3_q) | (lvl_q & (s2_q | s3_q));
    end
  end
  assign level = lvl_q;
endmodule : osc_pin_sync

//--- hdl/osc_ctrl_regs.sv
`timescale 1ns/1ps
`include "osc_map.svh"
module osc_ctrl_regs
  import osc_pkg::*;
(
  input  logic       clk,
  input  logic       rst_n,
  input  logic [3:0] bus_addr,
  input  logic [7:0] bus_wdata,
  input  logic       bus_wr,
  input  logic       bus_rd,
  output logic [7:0] bus_rdata,
  osc_ctrl_if.regs   ctl
);
  logic       pll_q;
  logic [3:0] freq_q;
  logic [1:0] scs_q;
  logic [7:0] rdata_q;
  logic [7:0] rd_d;
  wire        sel_ctrl = bus_addr == `OSC_ADDR_CTRL;
  wire        sel_stat = bus_addr == `OSC_ADDR_STAT;
  wire [7:0]  ctrl_rd  = {pll_q, freq_q, 1'b0, scs_q};

  always_comb begin
    if (!bus_rd) begin
      rd_d = 8'h00;
    end else if (sel_ctrl) begin
      rd_d = ctrl_rd;
    end else if (sel_stat) begin
      rd_d = ctl.status;
    end else begin
      rd_d = 8'h00;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pll_q  <= `OSC_PLL_RESET;
      freq_q <= `OSC_FREQ_RESET;
      scs_q  <= `OSC_SCS_RESET;
    end else if (bus_wr && sel_ctrl) begin
      pll_q  <= bus_wdata[`OSC_PLL_BIT];
      freq_q <= bus_wdata[`OSC_FREQ_HI:`OSC_FREQ_LO];
      scs_q  <= bus_wdata[`OSC_SCS_HI:`OSC_SCS_LO];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= rd_d;
    end
  end

  assign bus_rdata    = rdata_q;
  assign ctl.pll_sw   = pll_q;
  assign ctl.freq_sel = freq_q;
  assign ctl.clk_sel  = scs_q;

  AST_FREQ_RESET: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(rst_n) |-> freq_q == `OSC_FREQ_RESET)
    else $error("frequency select not at reset value after reset");
  AST_SCS_RESET: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(rst_n) |-> scs_q == `OSC_SCS_RESET && !ctl.clk_sel[1])
    else $error("clock select not cleared by reset");
  AST_RSVD_ZERO: assert property (@(posedge clk) disable iff (!rst_n)
    bus_rd && sel_ctrl |=> !bus_rdata[2] && bus_rdata[1:0] == scs_q)
    else $error("reserved control bit read back non-zero");
endmodule : osc_ctrl_regs

//--- bench/oscillator_select_switch_tb_top.sv
`timescale 1ns/1ps
module oscillator_select_switch_tb_top
  import osc_pkg::*;
;
  logic       clk;
  logic       rst_n;
  logic [3:0] bus_addr;
  logic [7:0] bus_wdata;
  logic       bus_wr;
  logic       bus_rd;
  logic [7:0] bus_rdata;
  logic [1:0] config_osc_select;
  logic       config_pll_force;
  logic       sleep_req;
  logic       lf_pin;
  logic       mf_pin;
  logic       hf_pin;
  logic       ext_pin;
  logic       pll_pin;
  logic       sys_clk;
  logic       pll_enable;
  logic       switch_busy;
  logic [4:0] active_source;
  logic [7:0] osc_cnt;
  int         fails;
  int         checks;
  int         busy_n;
  logic [7:0] rdat;

  // A short lock count keeps the PLL scenario quick.
  oscillator_select_switch #(.PLL_LOCK_CYCLES(20)) dut (
    .clk                    (clk),
    .rst_n                  (rst_n),
    .bus_addr               (bus_addr),
    .bus_wdata              (bus_wdata),
    .bus_wr                 (bus_wr),
    .bus_rd                 (bus_rd),
    .bus_rdata              (bus_rdata),
    .config_osc_select      (config_osc_select),
    .config_pll_force       (config_pll_force),
    .sleep_req              (sleep_req),
    .low_freq_internal_osc  (lf_pin),
    .mid_freq_internal_osc  (mf_pin),
    .high_freq_internal_osc (hf_pin),
    .external_clock_input   (ext_pin),
    .pll_osc                (pll_pin),
    .sys_clk                (sys_clk),
    .pll_enable             (pll_enable),
    .switch_busy            (switch_busy),
    .active_source          (active_source)
  );

  always #12.5 clk = ~clk;

  // Every oscillator pin holds each level at least four cycles, as the synchronisers need.
  always @(posedge clk) begin
    osc_cnt <= osc_cnt + 8'h01;
    hf_pin  <= osc_cnt[2];
    mf_pin  <= osc_cnt[3];
    ext_pin <= osc_cnt[4];
    lf_pin  <= osc_cnt[5];
    pll_pin <= osc_cnt[2] ^ osc_cnt[3];
  end

  task automatic final_report;
    $display("Summary: %0d checks, %0d fails", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : final_report

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_byte

  task automatic chk_flag(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_flag

  task automatic bus_write(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    bus_wr    <= 1'b1;
    bus_addr  <= a;
    bus_wdata <= d;
    @(posedge clk);
    bus_wr    <= 1'b0;
  endtask : bus_write

  task automatic bus_read(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    bus_rd   <= 1'b1;
    bus_addr <= a;
    @(posedge clk);
    bus_rd   <= 1'b0;
    #1;
    d = bus_rdata;
  endtask : bus_read

  // Busy stands from the edge after the trigger; the three cycles skipped here are counted into n.
  task automatic wait_switch(input logic [4:0] exp_src, output int n);
    int i;
    n = 3;
    repeat (3) @(posedge clk);
    #1;
    for (i = 0; i < 5000 && switch_busy !== 1'b0; i++) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (i == 5000) begin
      fails++;
      final_report();
    end
    chk_byte({3'h0, active_source}, {3'h0, exp_src});
  endtask : wait_switch

  task automatic do_reset;
    rst_n <= 1'b0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
  endtask : do_reset

  task automatic t_reset_state;
    bus_read(4'h0, rdat);
    chk_byte(rdat, 8'h38);
    wait_switch(SRC_MF, busy_n);
    bus_read(4'h1, rdat);
    chk_byte(rdat, 8'h02);
    bus_read(4'h9, rdat);
    chk_byte(rdat, 8'h00);
  endtask : t_reset_state

  task automatic t_to_high;
    logic [7:0] rises;
    logic       sys_prev;
    bus_write(4'h0, 8'h7c);
    bus_read(4'h0, rdat);
    chk_byte(rdat, 8'h78);
    wait_switch(SRC_HF, busy_n);
    chk_flag(busy_n >= 80, 1'b1);
    // The bench high oscillator has an eight-cycle period, so 32 cycles hold exactly four rising edges.
    rises    = 8'h00;
    sys_prev = sys_clk;
    repeat (32) begin
      @(posedge clk);
      #1;
      if (sys_clk && !sys_prev) begin
        rises = rises + 8'h01;
      end
      sys_prev = sys_clk;
    end
    chk_byte(rises, 8'h04);
  endtask : t_to_high

  task automatic t_same_source;
    bus_write(4'h0, 8'h68);
    wait_switch(SRC_HF, busy_n);
    chk_flag(busy_n < 80, 1'b1);
  endtask : t_same_source

  task automatic t_low_codes;
    bus_write(4'h0, 8'h38);
    wait_switch(SRC_MF, busy_n);
    bus_write(4'h0, 8'h10);
    wait_switch(SRC_MF, busy_n);
    bus_write(4'h0, 8'h00);
    wait_switch(SRC_LF, busy_n);
    // Resume needs a second low-oscillator edge (64 cycles here); the old clock divided by 16 bounds the low wait.
    chk_flag(busy_n >= 64 && busy_n < 320, 1'b1);
    bus_write(4'h0, 8'h18);
    wait_switch(SRC_HF, busy_n);
  endtask : t_low_codes

  task automatic t_pll;
    bus_write(4'h0, 8'hf0);
    repeat (2) @(posedge clk);
    #1;
    chk_flag(pll_enable, 1'b1);
    wait_switch(SRC_PLL, busy_n);
    bus_write(4'h0, 8'h70);
    repeat (2) @(posedge clk);
    #1;
    chk_flag(pll_enable, 1'b0);
    wait_switch(SRC_HF, busy_n);
    @(posedge clk);
    config_pll_force <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    chk_flag(pll_enable, 1'b1);
    wait_switch(SRC_PLL, busy_n);
    bus_read(4'h1, rdat);
    chk_byte(rdat, 8'h30);
    @(posedge clk);
    config_pll_force <= 1'b0;
    wait_switch(SRC_HF, busy_n);
  endtask : t_pll

  task automatic t_sleep;
    @(posedge clk);
    sleep_req <= 1'b1;
    repeat (20) @(posedge clk);
    bus_read(4'h1, rdat);
    chk_byte(rdat, 8'hc4);
    chk_flag(sys_clk, 1'b0);
    @(posedge clk);
    sleep_req <= 1'b0;
    wait_switch(SRC_HF, busy_n);
    chk_flag(busy_n < 80, 1'b1);
  endtask : t_sleep

  task automatic t_clock_select;
    @(posedge clk);
    config_osc_select <= 2'b01;
    wait_switch(SRC_EXT, busy_n);
    bus_write(4'h0, 8'h71);
    wait_switch(SRC_EXT, busy_n);
    bus_write(4'h0, 8'h72);
    wait_switch(SRC_HF, busy_n);
    bus_write(4'h0, 8'hf3);
    wait_switch(SRC_HF, busy_n);
    chk_flag(pll_enable, 1'b1);
  endtask : t_clock_select

  task automatic t_second_reset;
    do_reset();
    bus_read(4'h0, rdat);
    chk_byte(rdat, 8'h38);
    wait_switch(SRC_EXT, busy_n);
    @(posedge clk);
    config_osc_select <= 2'b00;
    wait_switch(SRC_MF, busy_n);
  endtask : t_second_reset

  initial begin
    clk               = 1'b0;
    rst_n             = 1'b0;
    bus_addr          = 4'h0;
    bus_wdata         = 8'h00;
    bus_wr            = 1'b0;
    bus_rd            = 1'b0;
    config_osc_select = 2'b00;
    config_pll_force  = 1'b0;
    sleep_req         = 1'b0;
    osc_cnt           = 8'h00;
    lf_pin            = 1'b0;
    mf_pin            = 1'b0;
    hf_pin            = 1'b0;
    ext_pin           = 1'b0;
    pll_pin           = 1'b0;
    fails             = 0;
    checks            = 0;
    do_reset();
    t_reset_state();
    t_to_high();
    t_same_source();
    t_low_codes();
    t_pll();
    t_sleep();
    t_clock_select();
    t_second_reset();
    final_report();
  end
endmodule : oscillator_select_switch_tb_top
